// >>> design/ppf_defs.svh
// Constants for the shared parallel/floppy pin block
`ifndef PPF_DEFS_SVH
`define PPF_DEFS_SVH

// Shared pin count and positions of the floppy functions
`define PPF_PIN_COUNT      8
`define PPF_PIN_INDEX      0
`define PPF_PIN_TRACK_ZERO 1
`define PPF_PIN_WPROT      2
`define PPF_PIN_RDATA      3
`define PPF_PIN_DCHANGE    4
`define PPF_PIN_NOCONN     5
`define PPF_PIN_MOTOR_A    6
`define PPF_PIN_SELECT_A   7

// Mode select field codes
`define PPF_SEL_PRINTER    2'h0
`define PPF_SEL_SINGLE     2'h1
`define PPF_SEL_DUAL       2'h2

// Config register six, pull-up disable bit
`define PPF_CFG_SIX_PULLUP_DIS 4

// Primary status synchroniser bit positions
`define PPF_PRI_INDEX      4
`define PPF_PRI_TRACK_ZERO 3
`define PPF_PRI_WPROT      2
`define PPF_PRI_RDATA      1
`define PPF_PRI_DCHANGE    0
// Primary inputs idle high, so syncs reset to inactive
`define PPF_PRI_IDLE       5'h1F

// Reset values
`define PPF_BYTE_RESET     8'h00
`define PPF_PULLUP_RESET   8'h00

`endif

// >>> design/ppf_pin_share.sv
// Pin sharing between parallel port data and extension floppy signals
//
// Behaviour
// - Pin two: data bit 2 or write protect
// - Pin three: data bit 3 or read data
// - Pin four: data bit 4 or disk change
// - Pin five: data bit 5, else tri-stated
// - Pin six: data, tri-state, or motor A
// - Pin seven: data, tri-state, or select A
// - Single mode serves B; dual serves A,B
// - Config six bit 4 disables primary pull-ups
// - Pins zero, one: pulled-up index, track zero
`timescale 1ns/1ns
`include "ppf_defs.svh"

module ppf_pin_share (
   // Clock, reset, enable
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   clk_en,
   // Configuration from same-clock logic
   input  wire logic [1:0]             mode_sel,
   input  wire logic [7:0]             config_reg_six,
   // Printer port side
   input  wire logic [7:0]             printer_data_out,
   input  wire logic                   printer_drive,
   output logic      [7:0]             printer_data_in,
   // Extension drive A requests, active high
   input  wire logic                   ext_motor_a_req,
   input  wire logic                   ext_select_a_req,
   // Shared data pins
   input  wire logic [7:0]             shared_data_pin_in,
   output ppf_pkg::ppf_pin_drive_t     shared_data_pin_drive,
   output logic      [7:0]             shared_pullup_en,
   // Primary floppy status pins, active low
   input  wire logic                   read_data_in,
   input  wire logic                   disk_change_in,
   input  wire logic                   write_protect_in,
   input  wire logic                   track_zero_in,
   input  wire logic                   index_in,
   output logic                        floppy_pullup_en,
   // Decoded status towards the controller
   output ppf_pkg::ppf_fdd_status_t    primary_status,
   output ppf_pkg::ppf_fdd_status_t    ext_status,
   output logic                        ext_serves_a,
   output logic                        ext_serves_b,
   output ppf_pkg::ppf_mode_t          mode
);

   // True in either extension floppy mode
   function automatic logic is_ext(input ppf_pkg::ppf_mode_t m);
      is_ext = (m == ppf_pkg::PPF_SINGLE_EXT) || (m == ppf_pkg::PPF_DUAL_EXT);
   endfunction

   // Fold active-low drive pins except read data into active-high status
   function automatic ppf_pkg::ppf_fdd_status_t decode_status(
      input logic idx_b, input logic trk_b, input logic wp_b,
      input logic rd,    input logic chg_b);
      ppf_pkg::ppf_fdd_status_t s;
      s.index_seen      = !idx_b;
      s.at_track_zero   = !trk_b;
      s.write_protected = !wp_b;
      s.read_data       = rd;
      s.disk_changed    = !chg_b;
      decode_status     = s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic [4:0] pri_meta;
   logic [4:0] pri_sync;

   // Two stages; only the second stage feeds logic
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta <= `PPF_BYTE_RESET;
         pin_sync <= `PPF_BYTE_RESET;
         pri_meta <= `PPF_PRI_IDLE;
         pri_sync <= `PPF_PRI_IDLE;
      end else if (clk_en) begin
         pin_meta <= shared_data_pin_in;
         pin_sync <= pin_meta;
         pri_meta <= {index_in, track_zero_in, write_protect_in, read_data_in,
                      disk_change_in};
         pri_sync <= pri_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Routing next values

   ppf_pkg::ppf_mode_t         next_mode;
   ppf_pkg::ppf_pin_drive_t    next_drive;
   logic [7:0]                 next_pullup;
   logic [7:0]                 next_printer_in;
   logic                       next_floppy_pullup_en;
   ppf_pkg::ppf_fdd_status_t   next_primary;
   ppf_pkg::ppf_fdd_status_t   next_ext;
   logic                       next_serves_a;
   logic                       next_serves_b;

   always_comb begin
      // mode field decode, reserved code falls back to printer
      case (mode_sel)
         `PPF_SEL_SINGLE: next_mode = ppf_pkg::PPF_SINGLE_EXT;
         `PPF_SEL_DUAL:   next_mode = ppf_pkg::PPF_DUAL_EXT;
         default:         next_mode = ppf_pkg::PPF_PRINTER;
      endcase

      // Printer defaults: all eight pins follow the port
      next_drive.out  = printer_data_out;
      next_drive.oe   = {8{printer_drive}};
      next_pullup     = `PPF_PULLUP_RESET;
      next_printer_in = pin_sync;
      next_ext        = '0;
      next_serves_a   = 1'b0;
      next_serves_b   = 1'b0;

      if (is_ext(next_mode)) begin
         // index, track zero, write protect, read data and disk change inputs, pulled up
         next_drive.out  = `PPF_BYTE_RESET;
         next_drive.oe   = `PPF_BYTE_RESET;
         next_pullup[`PPF_PIN_INDEX]      = 1'b1;
         next_pullup[`PPF_PIN_TRACK_ZERO] = 1'b1;
         next_pullup[`PPF_PIN_WPROT]      = 1'b1;
         next_pullup[`PPF_PIN_RDATA]      = 1'b1;
         next_pullup[`PPF_PIN_DCHANGE]    = 1'b1;
         // Printer sees nothing while the floppy owns the pins
         next_printer_in = `PPF_BYTE_RESET;
         next_ext = decode_status(pin_sync[`PPF_PIN_INDEX],
                                  pin_sync[`PPF_PIN_TRACK_ZERO],
                                  pin_sync[`PPF_PIN_WPROT],
                                  pin_sync[`PPF_PIN_RDATA],
                                  pin_sync[`PPF_PIN_DCHANGE]);
         // B always; A only in dual mode
         next_serves_b = 1'b1;
         next_serves_a = (next_mode == ppf_pkg::PPF_DUAL_EXT);
      end

      if (next_mode == ppf_pkg::PPF_DUAL_EXT) begin
         // motor A, low drives it on, open drain
         // select A, open drain, low selects
         next_drive.oe[`PPF_PIN_MOTOR_A]  = ext_motor_a_req;
         next_drive.oe[`PPF_PIN_SELECT_A] = ext_select_a_req;
      end

      // pull-up disable bit in config register six
      next_floppy_pullup_en = !config_reg_six[`PPF_CFG_SIX_PULLUP_DIS];
      // low disk change reads as changed
      // low write protect reads as protected
      // low track zero reads as head at track 0
      // read data stream passed to separator
      next_primary = decode_status(pri_sync[`PPF_PRI_INDEX],
                                   pri_sync[`PPF_PRI_TRACK_ZERO],
                                   pri_sync[`PPF_PRI_WPROT],
                                   pri_sync[`PPF_PRI_RDATA],
                                   pri_sync[`PPF_PRI_DCHANGE]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Output registers

   // Reset leaves every shared pin released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode                  <= ppf_pkg::PPF_PRINTER;
         shared_data_pin_drive <= '0;
         shared_pullup_en      <= `PPF_PULLUP_RESET;
         printer_data_in       <= `PPF_BYTE_RESET;
         floppy_pullup_en      <= 1'b1;
         primary_status        <= '0;
         ext_status            <= '0;
         ext_serves_a          <= 1'b0;
         ext_serves_b          <= 1'b0;
      end else if (clk_en) begin
         mode                  <= next_mode;
         shared_data_pin_drive <= next_drive;
         shared_pullup_en      <= next_pullup;
         printer_data_in       <= next_printer_in;
         floppy_pullup_en      <= next_floppy_pullup_en;
         primary_status        <= next_primary;
         ext_status            <= next_ext;
         ext_serves_a          <= next_serves_a;
         ext_serves_b          <= next_serves_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Two sync stages, the output register and the checked edge must all be enabled
   sequence s_run4;
      clk_en [*4];
   endsequence

   sequence s_ext_mode;
      mode == ppf_pkg::PPF_SINGLE_EXT || mode == ppf_pkg::PPF_DUAL_EXT;
   endsequence

   AST_WP_INPUT: assert property (s_ext_mode |->
      !shared_data_pin_drive.oe[`PPF_PIN_WPROT] && shared_pullup_en[`PPF_PIN_WPROT])
      else $error("write protect pin driven in floppy mode");
   AST_RDATA_INPUT: assert property (s_ext_mode |->
      !shared_data_pin_drive.oe[`PPF_PIN_RDATA] && shared_pullup_en[`PPF_PIN_RDATA])
      else $error("read data pin driven in floppy mode");
   AST_DCHG_PATH: assert property ((clk_en [*4]) ##0 s_ext_mode |->
      ext_status.disk_changed == !$past(shared_data_pin_in[`PPF_PIN_DCHANGE], 3))
      else $error("extension disk change path wrong");
   AST_PIN5_FLOAT: assert property (s_ext_mode |->
      !shared_data_pin_drive.oe[`PPF_PIN_NOCONN])
      else $error("pin five driven in floppy mode");
   AST_MOTOR_A: assert property (clk_en && mode_sel == `PPF_SEL_DUAL |=>
      shared_data_pin_drive.oe[`PPF_PIN_MOTOR_A] == $past(ext_motor_a_req)
      && !shared_data_pin_drive.out[`PPF_PIN_MOTOR_A])
      else $error("motor A pin not following request");
   AST_SELECT_SINGLE: assert property (mode == ppf_pkg::PPF_SINGLE_EXT |->
      !shared_data_pin_drive.oe[`PPF_PIN_SELECT_A])
      else $error("select A driven in single mode");
   AST_SERVES: assert property (clk_en && mode_sel == `PPF_SEL_SINGLE |=>
      ext_serves_b && !ext_serves_a)
      else $error("single mode must serve drive B only");
   AST_PULLUP_DIS: assert property (clk_en |=>
      floppy_pullup_en == !$past(config_reg_six[`PPF_CFG_SIX_PULLUP_DIS]))
      else $error("primary pull-up enable wrong");
   AST_PRI_STATUS: assert property (s_run4 |->
      primary_status.write_protected == !$past(write_protect_in, 3)
      && primary_status.at_track_zero == !$past(track_zero_in, 3))
      else $error("primary status decode wrong");
   AST_INDEX_PIN: assert property (s_ext_mode |->
      shared_pullup_en[`PPF_PIN_INDEX] && shared_pullup_en[`PPF_PIN_TRACK_ZERO])
      else $error("index or track zero pull-up missing");
   AST_PRINTER: assert property (clk_en && mode_sel == `PPF_SEL_PRINTER |=>
      shared_data_pin_drive.out == $past(printer_data_out)
      && shared_pullup_en == `PPF_PULLUP_RESET)
      else $error("printer routing wrong");

endmodule

// >>> design/ppf_pkg.sv
// Types for the shared parallel/floppy pin block
package ppf_pkg;

   // Pin routing mode
   typedef enum logic [1:0] {
      PPF_PRINTER    = 2'h0,
      PPF_SINGLE_EXT = 2'h1,
      PPF_DUAL_EXT   = 2'h2
   } ppf_mode_t;

   // Decoded drive status, active high except read_data, which keeps the raw pin level
   typedef struct packed {
      logic index_seen;
      logic at_track_zero;
      logic write_protected;
      logic read_data;
      logic disk_changed;
   } ppf_fdd_status_t;

   // Pin drive group
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } ppf_pin_drive_t;

endpackage

// >>> verif/ppf_drive_model.sv
// Floppy drive and printer model behind the shared and primary pins
`timescale 1ns/1ns
module ppf_drive_model (
   // Clock
   input  wire logic                    clk,
   // Block side of the pins
   input  wire ppf_pkg::ppf_pin_drive_t pin_drive,
   input  wire logic [7:0]              pullup_en,
   input  wire logic                    fdd_pullup_en,
   // Far side behaviour
   input  wire logic                    printer_on,
   input  wire logic [7:0]              printer_byte,
   input  wire logic [4:0]              ext_low,
   input  wire logic [4:0]              prim_low,
   input  wire logic                    prim_push,
   // Resolved pin levels
   output logic      [7:0]              pin_level,
   output logic      [4:0]              prim_level
);
   logic       tog;
   logic [7:0] ext_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Floating lines wander, so a stale level is never read as valid
   initial tog = 1'b0;
   always @(posedge clk) tog <= ~tog;
   assign ext_mask = {3'h0, ext_low};

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_drive.oe[i]) pin_level[i] = pin_drive.out[i];
         else if (printer_on) pin_level[i] = printer_byte[i];
         else if (ext_mask[i]) pin_level[i] = 1'b0;
         else if (pullup_en[i]) pin_level[i] = 1'b1;
         else pin_level[i] = tog;
      end
      for (int j = 0; j < 5; j++) begin
         if (prim_low[j]) prim_level[j] = 1'b0;
         else if (prim_push || fdd_pullup_en) prim_level[j] = 1'b1;
         else prim_level[j] = tog;
      end
   end
endmodule

// >>> verif/test_parallel_port_floppy_pin_share.sv
// Self-checking bench for the shared parallel/floppy pin block
`timescale 1ns/1ns
module test_parallel_port_floppy_pin_share;
   logic                     clk, rst_b, clk_en, printer_drive, printer_on, prim_push;
   logic                     ext_motor_a_req, ext_select_a_req, floppy_pullup_en;
   logic                     ext_serves_a, ext_serves_b;
   logic [1:0]               mode_sel;
   logic [7:0]               config_reg_six, printer_data_out, printer_data_in;
   logic [7:0]               pin_level, shared_pullup_en, printer_byte;
   logic [4:0]               ext_low, prim_low, prim_level;
   ppf_pkg::ppf_pin_drive_t  shared_data_pin_drive;
   ppf_pkg::ppf_fdd_status_t primary_status, ext_status;
   ppf_pkg::ppf_mode_t       mode;
   int                       num_errors, total_checks, cycles;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and instances
   initial clk = 1'b0;
   always #25 clk = ~clk;

   ppf_pin_share dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .mode_sel(mode_sel),
      .config_reg_six(config_reg_six), .printer_data_out(printer_data_out),
      .printer_drive(printer_drive), .printer_data_in(printer_data_in),
      .ext_motor_a_req(ext_motor_a_req), .ext_select_a_req(ext_select_a_req),
      .shared_data_pin_in(pin_level), .shared_data_pin_drive(shared_data_pin_drive),
      .shared_pullup_en(shared_pullup_en), .read_data_in(prim_level[1]),
      .disk_change_in(prim_level[0]), .write_protect_in(prim_level[2]),
      .track_zero_in(prim_level[3]), .index_in(prim_level[4]),
      .floppy_pullup_en(floppy_pullup_en), .primary_status(primary_status),
      .ext_status(ext_status), .ext_serves_a(ext_serves_a),
      .ext_serves_b(ext_serves_b), .mode(mode));

   ppf_drive_model far_u (.clk(clk), .pin_drive(shared_data_pin_drive),
      .pullup_en(shared_pullup_en), .fdd_pullup_en(floppy_pullup_en),
      .printer_on(printer_on), .printer_byte(printer_byte), .ext_low(ext_low),
      .prim_low(prim_low), .prim_push(prim_push), .pin_level(pin_level),
      .prim_level(prim_level));

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Settle past the edge so registered outputs have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cfg(input logic [1:0] m, input logic mr, input logic sr, input logic pd);
      @(posedge clk);
      mode_sel         <= m;
      ext_motor_a_req  <= mr;
      ext_select_a_req <= sr;
      printer_drive    <= pd;
      printer_data_out <= m[0] ? 8'h5A : 8'hA5;
      tick(1);
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_printer();
      for (int m = 0; m < 4; m += 3) begin
         cfg(m[1:0], 1'b1, 1'b1, 1'b1);
         chk(shared_data_pin_drive, m[0] ? 16'h5AFF : 16'hA5FF);
         chk({8'h00, shared_pullup_en}, 16'h0000);
      end
      cfg(2'h0, 1'b0, 1'b0, 1'b0);
      @(posedge clk);
      printer_on <= 1'b1;
      tick(4);
      chk({8'h00, printer_data_in}, 16'h003C);
      chk({11'h000, ext_status}, 16'h0000);
   endtask

   task automatic t_single();
      @(posedge clk);
      printer_on <= 1'b0;
      cfg(2'h1, 1'b1, 1'b1, 1'b1);
      chk(shared_data_pin_drive, 16'h0000);
      chk({8'h00, shared_pullup_en}, 16'h001F);
      chk({14'h0, ext_serves_a, ext_serves_b}, 16'h0001);
      @(posedge clk);
      ext_low <= 5'h15;
      tick(4);
      chk({11'h000, ext_status}, 16'h0017);
      chk({8'h00, printer_data_in}, 16'h0000);
   endtask

   task automatic t_dual();
      cfg(2'h2, 1'b1, 1'b0, 1'b0);
      chk(shared_data_pin_drive, 16'h0040);
      cfg(2'h2, 1'b0, 1'b1, 1'b0);
      chk(shared_data_pin_drive, 16'h0080);
      chk({14'h0, ext_serves_a, ext_serves_b}, 16'h0003);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         ext_low <= {1'b0, k[0], 3'h0};
         tick(4);
         chk({11'h000, ext_status}, k[0] ? 16'h0000 : 16'h0002);
      end
      // Frozen enable must hold the routing
      @(posedge clk);
      clk_en   <= 1'b0;
      mode_sel <= 2'h0;
      tick(2);
      chk({14'h0, mode}, 16'h0002);
      @(posedge clk);
      clk_en <= 1'b1;
   endtask

   task automatic t_primary();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         prim_low       <= (i < 5) ? 5'h01 << i : 5'h00;
         prim_push      <= i[0];
         config_reg_six <= i[0] ? 8'h10 : 8'hEF;
         tick(4);
         chk({15'h0, floppy_pullup_en}, {15'h0, ~i[0]});
         chk({11'h000, primary_status}, {11'h000, prim_low ^ 5'h02});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence and hang guard
   initial begin
      {rst_b, clk_en, printer_drive, printer_on, prim_push} = 5'h00;
      {ext_motor_a_req, ext_select_a_req, mode_sel} = 4'h0;
      {config_reg_six, printer_data_out, ext_low, prim_low} = 26'h0;
      printer_byte = 8'h3C;
      num_errors   = 0;
      total_checks = 0;
      tick(5);
      chk({15'h0, floppy_pullup_en}, 16'h0001);
      @(posedge clk);
      rst_b  <= 1'b1;
      clk_en <= 1'b1;
      t_printer();
      t_single();
      t_dual();
      t_primary();
      wrap_up();
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end
endmodule
